/* bench/motor_fault_supervisor_bench.sv */
// Self-checking bench for the fault supervisor
`timescale 1ns/100ps
module motor_fault_supervisor_bench;
  logic        mclk, resetn, pushInput, clockErrorIn, prechargeFailIn, restartParamChanged, objReadStrobe;
  logic        keySwitchInput, pdoReceived, nmtReceived, objReadValid, currentCutback, shutdownAll;
  logic        shutdownThrottle, shutdownInterlock, pushMode;
  logic [11:0] capVoltage, nominalVoltage;
  logic [15:0] pdoTimeoutMs, objIndex, errorCategory;
  logic [9:0]  wip [3];
  logic [9:0]  wiperFaultLow, wiperFaultHigh;
  logic [5:0]  wiperActions;
  logic [7:0]  objReadData, faultCode, beaconPattern;
  logic [2:0]  shutdownWiper;
  int          fail_count = 0, num_checks = 0, cycles = 0;
  `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
  motor_fault_supervisor #(.TICK_CYCLES(4)) u_dut (.wiperInputOne(wip[0]), .wiperInputTwo(wip[1]),
    .wiperInputThree(wip[2]), .*);
  net_master_model u_net (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Object read: strobe one cycle, answer on the next edge
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    @(posedge mclk);
    objReadStrobe <= 1'b1;
    objIndex <= idx;
    @(posedge mclk);
    objReadStrobe <= 1'b0;
    #1;
    `CHK("readValid", 1'b1, objReadValid)
    `CHK("readData", exp, objReadData)
  endtask
  task automatic rep(input logic [7:0] c, b, input logic [15:0] k);
    `CHK("faultCode", c, faultCode)
    `CHK("beacon", b, beaconPattern)
    `CHK("category", k, errorCategory)
  endtask
  // Overvoltage at and just above the limit
  task automatic t_overvolt();
    @(posedge mclk) capVoltage <= 12'h07D;
    wt(4);
    `CHK("cutbackAtLimit", 1'b0, currentCutback)
    @(posedge mclk) capVoltage <= 12'h07E;
    wt(4);
    `CHK("cutback", 1'b1, currentCutback)
    rep(fault_sup_pkg::CODE_OVERVOLT, fault_sup_pkg::BEACON_OVERVOLT, fault_sup_pkg::CAT_GENERAL);
    rd(fault_sup_pkg::IDX_GROUP_2, 8'h08);
    @(posedge mclk) capVoltage <= 12'h07D;
    wt(4);
    rd(fault_sup_pkg::IDX_GROUP_2, 8'h00);
  endtask
  // Every wiper with every action, action 1 at the high limit and the others at the low limit
  task automatic t_wipers();
    for (int w = 0; w < 3; w++) begin
      for (int a = 0; a < 4; a++) begin
        @(posedge mclk);
        wip[w] <= (a == 1) ? 10'h3F0 : 10'h010;
        wiperActions <= 6'(a << (2 * w));
        wt(4);
        rd(fault_sup_pkg::IDX_GROUP_1, 8'h08 << w);
        `CHK("wiperCode", fault_sup_pkg::CODE_WIPER_1 + 8'(w), faultCode)
        `CHK("wiperBeacon", fault_sup_pkg::BEACON_WIPER_1 + 8'(w), beaconPattern)
        `CHK("wiperShut", (a == 0) ? 3'h1 << w : (a > 1) ? 3'h7 : 3'h0, shutdownWiper)
        `CHK("throttleShut", a != 0, shutdownThrottle)
        @(posedge mclk) wip[w] <= 10'h200;
        wt(4);
        `CHK("wiperClear", fault_sup_pkg::CODE_NONE, faultCode)
      end
    end
  endtask
  task automatic t_param();
    @(posedge mclk) restartParamChanged <= 1'b1;
    @(posedge mclk) restartParamChanged <= 1'b0;
    wt(30);
    `CHK("inhibit", 2'h3, {shutdownThrottle, shutdownInterlock})
    rep(fault_sup_pkg::CODE_PARAM_CHG, fault_sup_pkg::BEACON_PARAM_CHG, fault_sup_pkg::CAT_GENERAL);
    rd(fault_sup_pkg::IDX_GROUP_3, 8'h08);
    u_net.cycleKey();
    wt(8);
    rd(fault_sup_pkg::IDX_GROUP_3, 8'h00);
  endtask
  // Message gap over two ms, cleared by management message and by key
  task automatic t_pdo();
    u_net.pulse(1'b0);
    wt(6);
    `CHK("pdoEarly", 1'b0, shutdownAll)
    wt(20);
    rep(fault_sup_pkg::CODE_PDO, fault_sup_pkg::BEACON_PDO, fault_sup_pkg::CAT_GENERAL);
    rd(fault_sup_pkg::IDX_GROUP_2, 8'h02);
    u_net.pulse(1'b1);
    wt(4);
    rd(fault_sup_pkg::IDX_GROUP_2, 8'h00);
    u_net.pulse(1'b0);
    wt(30);
    `CHK("pdoAgain", 1'b1, shutdownAll)
    u_net.cycleKey();
    wt(8);
    `CHK("pdoKeyClear", 1'b0, shutdownAll)
  endtask
  // One-cycle pin pulse, latched until key cycle
  task automatic t_latch(input bit clk);
    @(posedge mclk);
    clockErrorIn <= clk;
    prechargeFailIn <= !clk;
    @(posedge mclk);
    clockErrorIn <= 1'b0;
    prechargeFailIn <= 1'b0;
    wt(20);
    `CHK("latchShut", 1'b1, shutdownAll)
    if (clk) rep(fault_sup_pkg::CODE_CLOCK, fault_sup_pkg::BEACON_CLOCK, fault_sup_pkg::CAT_INTERNAL);
    else rep(fault_sup_pkg::CODE_PRECHARGE, fault_sup_pkg::BEACON_PRECHARGE, fault_sup_pkg::CAT_GENERAL);
    if (clk) rd(fault_sup_pkg::IDX_GROUP_8, 8'h04);
    else rd(fault_sup_pkg::IDX_GROUP_2, 8'h80);
    u_net.cycleKey();
    wt(8);
    `CHK("latchClear", 1'b0, shutdownAll)
  endtask
  task automatic t_push();
    @(posedge mclk) pushInput <= 1'b1;
    wt(8);
    rep(fault_sup_pkg::CODE_PUSH, fault_sup_pkg::BEACON_PUSH, fault_sup_pkg::CAT_INTERNAL);
    `CHK("pushMode", 1'b1, pushMode)
    rd(fault_sup_pkg::IDX_GROUP_6, 8'h01);
    rd(16'h408E, 8'h00);
    @(posedge mclk) pushInput <= 1'b0;
    wt(8);
    rd(fault_sup_pkg::IDX_GROUP_6, 8'h00);
  endtask
  initial begin
    {resetn, pushInput, clockErrorIn, prechargeFailIn, restartParamChanged, objReadStrobe} = 6'h00;
    {capVoltage, nominalVoltage, pdoTimeoutMs, objIndex} = {12'h064, 12'h064, 16'h0002, 16'h0000};
    {wip[0], wip[1], wip[2], wiperFaultLow, wiperFaultHigh} = {10'h200, 10'h200, 10'h200, 10'h010, 10'h3F0};
    wiperActions = 6'h00;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    wt(2);
    t_overvolt();
    t_wipers();
    t_param();
    t_pdo();
    t_latch(1'b1);
    t_latch(1'b0);
    t_push();
    rd(16'h3091, 8'h00);
    end_sim();
  end
endmodule

/* bench/motor_fault_supervisor_sva.sv */
// Assertion checker on the fault supervisor ports
`timescale 1ns/100ps
module motor_fault_supervisor_sva #(
  parameter int VOLT_WIDTH  = 12,
  parameter int WIPER_WIDTH = 10
) (
  input wire logic                   mclk, resetn, keySwitchInput, pushInput,
  input wire logic                   restartParamChanged, objReadStrobe, objReadValid,
  input wire logic                   currentCutback, shutdownAll, shutdownThrottle,
  input wire logic                   shutdownInterlock, pushMode,
  input wire logic [VOLT_WIDTH-1:0]  capVoltage, nominalVoltage,
  input wire logic [WIPER_WIDTH-1:0] wiperInputOne, wiperFaultLow, wiperFaultHigh,
  input wire logic [5:0]             wiperActions,
  input wire logic [15:0]            objIndex, errorCategory,
  input wire logic [7:0]             objReadData, faultCode, beaconPattern,
  input wire logic [2:0]             shutdownWiper
);
  // ==========================================================
  // Conditions seen at the inputs
  wire ovHigh = 32'(capVoltage) * 100 > 32'(nominalVoltage) * 125;
  wire w1Bad  = wiperInputOne <= wiperFaultLow || wiperInputOne >= wiperFaultHigh;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence keyHeld; keySwitchInput [*6]; endsequence
  sequence clockShown; faultCode == fault_sup_pkg::CODE_CLOCK; endsequence
  // ==========================================================
  // Properties
  ovSet_a: assert property (ovHigh [*3] |-> currentCutback)
    else $error("cutback missing");
  ovClear_a: assert property (!ovHigh [*3] |-> !currentCutback)
    else $error("cutback stuck");
  wiperShut_a: assert property ((w1Bad && wiperActions[1:0] == 2'h0) [*3] |-> shutdownWiper[0])
    else $error("wiper shutdown missing");
  clockHold_a: assert property (keyHeld ##0 clockShown |=> clockShown)
    else $error("clock fault dropped");
  clockReport_a: assert property (clockShown |-> shutdownAll && beaconPattern == fault_sup_pkg::BEACON_CLOCK
    && errorCategory == fault_sup_pkg::CAT_INTERNAL) else $error("clock report wrong");
  allForces_a: assert property (shutdownAll |-> shutdownThrottle && shutdownInterlock && &shutdownWiper)
    else $error("shutdown incomplete");
  readValid_a: assert property (objReadStrobe |=> objReadValid)
    else $error("read valid missing");
  readIdle_a: assert property (!objReadStrobe |=> !objReadValid)
    else $error("stray read valid");
  unmapped_a: assert property (objReadStrobe && objIndex[15:8] != 8'h30 |=> objReadData == 8'h00)
    else $error("unmapped read not zero");
  paramInhibit_a: assert property (restartParamChanged |-> ##[1:3] shutdownThrottle && shutdownInterlock)
    else $error("inhibit missing");
  pushOn_a: assert property (pushInput [*6] |-> pushMode)
    else $error("push mode missing");
  pushOff_a: assert property (!pushInput [*6] |-> !pushMode)
    else $error("push mode stuck");
endmodule
bind motor_fault_supervisor motor_fault_supervisor_sva #(.VOLT_WIDTH(VOLT_WIDTH), .WIPER_WIDTH(WIPER_WIDTH)) u_sva (.*);

/* bench/net_master_model.sv */
// Model of the network master and key switch
`timescale 1ns/100ps
module net_master_model (
  input  wire logic mclk,
  output logic      pdoReceived,
  output logic      nmtReceived,
  output logic      keySwitchInput
);
  initial begin
    pdoReceived = 1'b0;
    nmtReceived = 1'b0;
    keySwitchInput = 1'b1;
  end
  // One-cycle message pulse, process data or management
  task automatic pulse(input bit nmt);
    @(posedge mclk);
    nmtReceived <= nmt;
    pdoReceived <= !nmt;
    @(posedge mclk);
    nmtReceived <= 1'b0;
    pdoReceived <= 1'b0;
  endtask
  // Key off long enough to pass the synchroniser, then on
  task automatic cycleKey();
    @(posedge mclk);
    keySwitchInput <= 1'b0;
    repeat (6) @(posedge mclk);
    keySwitchInput <= 1'b1;
  endtask
endmodule

/* rtl/fault_sup_pkg.sv */
// Constants shared by the fault supervisor modules
package fault_sup_pkg;

  // ==========================================================
  // Status group object indices
  localparam logic [15:0] IDX_GROUP_1 = 16'h3089;
  localparam logic [15:0] IDX_GROUP_2 = 16'h308A;
  localparam logic [15:0] IDX_GROUP_3 = 16'h308B;
  localparam logic [15:0] IDX_GROUP_6 = 16'h308E;
  localparam logic [15:0] IDX_GROUP_8 = 16'h3090;
  localparam logic [7:0]  GROUP_RESET = 8'h00;

  // ==========================================================
  // Bit positions within the status groups
  localparam int BIT_WIPER_ONE   = 3;  // Group 1
  localparam int BIT_WIPER_TWO   = 4;  // Group 1
  localparam int BIT_WIPER_THREE = 5;  // Group 1
  localparam int BIT_PDO_TIMEOUT = 1;  // Group 2
  localparam int BIT_OVERVOLT    = 3;  // Group 2
  localparam int BIT_PRECHARGE   = 7;  // Group 2
  localparam int BIT_PARAM_CHG   = 3;  // Group 3
  localparam int BIT_PUSH        = 0;  // Group 6
  localparam int BIT_CLOCK_CHECK = 2;  // Group 8

  // ==========================================================
  // Display codes, beacon groups and error categories
  localparam logic [7:0]  CODE_NONE      = 8'h00;
  localparam logic [7:0]  CODE_OVERVOLT  = 8'd98;
  localparam logic [7:0]  CODE_PARAM_CHG = 8'd81;
  localparam logic [7:0]  CODE_PDO       = 8'd19;
  localparam logic [7:0]  CODE_CLOCK     = 8'd2;
  localparam logic [7:0]  CODE_WIPER_1   = 8'd41;
  localparam logic [7:0]  CODE_WIPER_2   = 8'd42;
  localparam logic [7:0]  CODE_WIPER_3   = 8'd43;
  localparam logic [7:0]  CODE_PRECHARGE = 8'd54;
  localparam logic [7:0]  CODE_PUSH      = 8'd117;
  localparam logic [7:0]  BEACON_OVERVOLT  = 8'h3E;  // 3-14
  localparam logic [7:0]  BEACON_PARAM_CHG = 8'h56;  // 5-6
  localparam logic [7:0]  BEACON_PDO       = 8'h41;  // 4-1
  localparam logic [7:0]  BEACON_CLOCK     = 8'h12;  // 1-2
  localparam logic [7:0]  BEACON_WIPER_1   = 8'h51;  // 5-1
  localparam logic [7:0]  BEACON_WIPER_2   = 8'h52;  // 5-2
  localparam logic [7:0]  BEACON_WIPER_3   = 8'h53;  // 5-3
  localparam logic [7:0]  BEACON_PRECHARGE = 8'h54;  // 5-4
  localparam logic [7:0]  BEACON_PUSH      = 8'h18;  // 1-8
  localparam logic [7:0]  BEACON_NONE      = 8'h00;
  localparam logic [15:0] CAT_GENERAL  = 16'h1000;
  localparam logic [15:0] CAT_INTERNAL = 16'h1001;
  localparam logic [15:0] CAT_NONE     = 16'h0000;

  // ==========================================================
  // Overvoltage threshold and timing
  localparam int OVERVOLT_PERCENT = 125;
  localparam int CLK_PERIOD_NS    = 25;
  localparam int MS_IN_NS         = 1000000;
  localparam int MS_TICK_CYCLES   = MS_IN_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Programmed action for a wiper fault
  typedef enum logic [1:0] {
    WIPER_ACT_SELF     = 2'h0,
    WIPER_ACT_THROTTLE = 2'h1,
    WIPER_ACT_ALL      = 2'h2
  } wiper_action_t;

endpackage

/* rtl/motor_fault_supervisor.sv */
// Fault supervisor: detection, shutdown actions and fault reporting
`timescale 1ns/100ps
module motor_fault_supervisor #(
  parameter int TICK_CYCLES = fault_sup_pkg::MS_TICK_CYCLES,
  parameter int VOLT_WIDTH  = 12,
  parameter int WIPER_WIDTH = 10,
  parameter int MS_WIDTH    = 16
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   keySwitchInput,
  input  wire logic                   pushInput,
  input  wire logic                   clockErrorIn,
  input  wire logic                   prechargeFailIn,
  input  wire logic [VOLT_WIDTH-1:0]  capVoltage,
  input  wire logic [VOLT_WIDTH-1:0]  nominalVoltage,
  input  wire logic                   restartParamChanged,
  input  wire logic                   pdoReceived,
  input  wire logic                   nmtReceived,
  input  wire logic [MS_WIDTH-1:0]    pdoTimeoutMs,
  input  wire logic [WIPER_WIDTH-1:0] wiperInputOne,
  input  wire logic [WIPER_WIDTH-1:0] wiperInputTwo,
  input  wire logic [WIPER_WIDTH-1:0] wiperInputThree,
  input  wire logic [WIPER_WIDTH-1:0] wiperFaultLow,
  input  wire logic [WIPER_WIDTH-1:0] wiperFaultHigh,
  input  wire logic [5:0]             wiperActions,
  input  wire logic                   objReadStrobe,
  input  wire logic [15:0]            objIndex,
  output logic [7:0]                  objReadData,
  output logic                        objReadValid,
  output logic                        currentCutback,
  output logic                        shutdownAll,
  output logic                        shutdownThrottle,
  output logic                        shutdownInterlock,
  output logic [2:0]                  shutdownWiper,
  output logic                        pushMode,
  output logic [7:0]                  faultCode,
  output logic [7:0]                  beaconPattern,
  output logic [15:0]                 errorCategory
);

  localparam int NSYNC = 4;

  logic [NSYNC-1:0] pinMeta_reg;
  logic [NSYNC-1:0] pinSync_reg;
  logic             keyOnDly_reg;
  logic             keyCycle;
  logic             keyOn;
  logic             pushIn;
  logic             clockErr;
  logic             prechargeErr;
  logic             overVolt_reg;
  logic             paramChg_reg;
  logic             clockChk_reg;
  logic             precharge_reg;
  logic             pushAlert_reg;
  logic             pdoTimeout;
  logic [2:0]       wiperFault;
  logic [19:0]      capScaled;
  logic [19:0]      limitScaled;
  logic [7:0]       group1;
  logic [7:0]       group2;
  logic [7:0]       group3;
  logic [7:0]       group6;
  logic [7:0]       group8;
  logic             throttleOff;
  logic             allOff;
  logic [2:0]       wiperOff;
  logic [7:0]       code_next;
  logic [7:0]       beacon_next;
  logic [15:0]      category_next;

  // ==========================================================
  // Two-stage synchronisers for asynchronous pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end else begin
      pinMeta_reg <= {prechargeFailIn, clockErrorIn, pushInput, keySwitchInput};
      pinSync_reg <= pinMeta_reg;
    end
  end
  assign keyOn        = pinSync_reg[0];
  assign pushIn       = pinSync_reg[1];
  assign clockErr     = pinSync_reg[2];
  assign prechargeErr = pinSync_reg[3];

  // ==========================================================
  // Key-switch cycle: a key-off edge clears latched faults
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      keyOnDly_reg <= 1'b0;
    end else begin
      keyOnDly_reg <= keyOn;
    end
  end
  assign keyCycle = keyOnDly_reg && !keyOn;

  // ==========================================================
  // Overvoltage compare: 100 x Vcap against 125 x nominal
  assign capScaled   = 20'(capVoltage) * 20'd100;
  assign limitScaled = 20'(nominalVoltage) * 20'(fault_sup_pkg::OVERVOLT_PERCENT);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      overVolt_reg <= 1'b0;
    end else begin
      overVolt_reg <= capScaled > limitScaled;
    end
  end

  // ==========================================================
  // Latched parameter-change fault, set wins over key cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      paramChg_reg <= 1'b0;
    end else if (restartParamChanged) begin
      paramChg_reg <= 1'b1;
    end else if (keyCycle) begin
      paramChg_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Latched clock-check fault
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clockChk_reg <= 1'b0;
    end else if (clockErr) begin
      clockChk_reg <= 1'b1;
    end else if (keyCycle) begin
      clockChk_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Latched precharge fault
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      precharge_reg <= 1'b0;
    end else if (prechargeErr) begin
      precharge_reg <= 1'b1;
    end else if (keyCycle) begin
      precharge_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Push alert follows the push input
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pushAlert_reg <= 1'b0;
    end else begin
      pushAlert_reg <= pushIn;
    end
  end

  // ==========================================================
  // Process-data timeout watchdog
  pdo_watchdog #(
    .TICK_CYCLES (TICK_CYCLES),
    .MS_WIDTH    (MS_WIDTH)
  ) u_pdo_watchdog (
    .mclk        (mclk),
    .resetn      (resetn),
    .pdoReceived (pdoReceived),
    .nmtReceived (nmtReceived),
    .keyCycle    (keyCycle),
    .timeoutMs   (pdoTimeoutMs),
    .timedOut    (pdoTimeout)
  );

  // ==========================================================
  // Wiper range checks, one per input
  wiper_check_if #(.WIDTH(WIPER_WIDTH)) wiperIf [3] ();
  assign wiperIf[0].sample = wiperInputOne;
  assign wiperIf[1].sample = wiperInputTwo;
  assign wiperIf[2].sample = wiperInputThree;
  for (genvar i = 0; i < 3; i++) begin : g_wiper
    assign wiperIf[i].faultLow  = wiperFaultLow;
    assign wiperIf[i].faultHigh = wiperFaultHigh;
    assign wiperFault[i]        = wiperIf[i].inFault;
    wiper_range_check u_check (
      .mclk   (mclk),
      .resetn (resetn),
      .chk    (wiperIf[i])
    );
  end

  // ==========================================================
  // Programmed wiper actions and shutdown combination
  always_comb begin
    wiperOff    = 3'h0;
    throttleOff = paramChg_reg;
    allOff      = pdoTimeout || clockChk_reg || precharge_reg;
    for (int k = 0; k < 3; k++) begin
      if (wiperFault[k]) begin
        unique case (fault_sup_pkg::wiper_action_t'(wiperActions[2*k +: 2]))
          fault_sup_pkg::WIPER_ACT_SELF:     wiperOff[k] = 1'b1;
          fault_sup_pkg::WIPER_ACT_THROTTLE: throttleOff = 1'b1;
          fault_sup_pkg::WIPER_ACT_ALL:      allOff      = 1'b1;
          default:                           allOff      = 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Registered action outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      currentCutback    <= 1'b0;
      shutdownAll       <= 1'b0;
      shutdownThrottle  <= 1'b0;
      shutdownInterlock <= 1'b0;
      shutdownWiper     <= 3'h0;
      pushMode          <= 1'b0;
    end else begin
      currentCutback    <= overVolt_reg;
      shutdownAll       <= allOff;
      shutdownThrottle  <= throttleOff || allOff;
      shutdownInterlock <= paramChg_reg || allOff;
      shutdownWiper     <= wiperOff | {3{allOff}};
      pushMode          <= pushAlert_reg;
    end
  end

  // ==========================================================
  // Status groups built from the fault flags
  always_comb begin
    group1 = fault_sup_pkg::GROUP_RESET;
    group2 = fault_sup_pkg::GROUP_RESET;
    group3 = fault_sup_pkg::GROUP_RESET;
    group6 = fault_sup_pkg::GROUP_RESET;
    group8 = fault_sup_pkg::GROUP_RESET;
    group1[fault_sup_pkg::BIT_WIPER_ONE]   = wiperFault[0];
    group1[fault_sup_pkg::BIT_WIPER_TWO]   = wiperFault[1];
    group1[fault_sup_pkg::BIT_WIPER_THREE] = wiperFault[2];
    group2[fault_sup_pkg::BIT_PDO_TIMEOUT] = pdoTimeout;
    group2[fault_sup_pkg::BIT_OVERVOLT]    = overVolt_reg;
    group2[fault_sup_pkg::BIT_PRECHARGE]   = precharge_reg;
    group3[fault_sup_pkg::BIT_PARAM_CHG]   = paramChg_reg;
    group6[fault_sup_pkg::BIT_PUSH]        = pushAlert_reg;
    group8[fault_sup_pkg::BIT_CLOCK_CHECK] = clockChk_reg;
  end

  // ==========================================================
  // Object read port: indexed status groups, zero elsewhere
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      objReadData  <= 8'h00;
      objReadValid <= 1'b0;
    end else begin
      objReadValid <= objReadStrobe;
      if (objReadStrobe) begin
        unique case (objIndex)
          fault_sup_pkg::IDX_GROUP_1: objReadData <= group1;
          fault_sup_pkg::IDX_GROUP_2: objReadData <= group2;
          fault_sup_pkg::IDX_GROUP_3: objReadData <= group3;
          fault_sup_pkg::IDX_GROUP_6: objReadData <= group6;
          fault_sup_pkg::IDX_GROUP_8: objReadData <= group8;
          default:                    objReadData <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Report of the most severe active fault
  always_comb begin
    code_next     = fault_sup_pkg::CODE_NONE;
    beacon_next   = fault_sup_pkg::BEACON_NONE;
    category_next = fault_sup_pkg::CAT_NONE;
    if (clockChk_reg) begin
      code_next     = fault_sup_pkg::CODE_CLOCK;
      beacon_next   = fault_sup_pkg::BEACON_CLOCK;
      category_next = fault_sup_pkg::CAT_INTERNAL;
    end else if (precharge_reg) begin
      code_next     = fault_sup_pkg::CODE_PRECHARGE;
      beacon_next   = fault_sup_pkg::BEACON_PRECHARGE;
      category_next = fault_sup_pkg::CAT_GENERAL;
    end else if (pdoTimeout) begin
      code_next     = fault_sup_pkg::CODE_PDO;
      beacon_next   = fault_sup_pkg::BEACON_PDO;
      category_next = fault_sup_pkg::CAT_GENERAL;
    end else if (wiperFault[0]) begin
      code_next     = fault_sup_pkg::CODE_WIPER_1;
      beacon_next   = fault_sup_pkg::BEACON_WIPER_1;
      category_next = fault_sup_pkg::CAT_GENERAL;
    end else if (wiperFault[1]) begin
      code_next     = fault_sup_pkg::CODE_WIPER_2;
      beacon_next   = fault_sup_pkg::BEACON_WIPER_2;
      category_next = fault_sup_pkg::CAT_GENERAL;
    end else if (wiperFault[2]) begin
      code_next     = fault_sup_pkg::CODE_WIPER_3;
      beacon_next   = fault_sup_pkg::BEACON_WIPER_3;
      category_next = fault_sup_pkg::CAT_GENERAL;
    end else if (paramChg_reg) begin
      code_next     = fault_sup_pkg::CODE_PARAM_CHG;
      beacon_next   = fault_sup_pkg::BEACON_PARAM_CHG;
      category_next = fault_sup_pkg::CAT_GENERAL;
    end else if (overVolt_reg) begin
      code_next     = fault_sup_pkg::CODE_OVERVOLT;
      beacon_next   = fault_sup_pkg::BEACON_OVERVOLT;
      category_next = fault_sup_pkg::CAT_GENERAL;
    end else if (pushAlert_reg) begin
      code_next     = fault_sup_pkg::CODE_PUSH;
      beacon_next   = fault_sup_pkg::BEACON_PUSH;
      category_next = fault_sup_pkg::CAT_INTERNAL;
    end
  end

  // ==========================================================
  // Registered report outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      faultCode     <= fault_sup_pkg::CODE_NONE;
      beaconPattern <= fault_sup_pkg::BEACON_NONE;
      errorCategory <= fault_sup_pkg::CAT_NONE;
    end else begin
      faultCode     <= code_next;
      beaconPattern <= beacon_next;
      errorCategory <= category_next;
    end
  end

endmodule

/* rtl/pdo_watchdog.sv */
// Watchdog on the gap between received process-data messages
`timescale 1ns/100ps
module pdo_watchdog #(
  parameter int TICK_CYCLES = fault_sup_pkg::MS_TICK_CYCLES,
  parameter int MS_WIDTH    = 16
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic                pdoReceived,
  input  wire logic                nmtReceived,
  input  wire logic                keyCycle,
  input  wire logic [MS_WIDTH-1:0] timeoutMs,
  output logic                     timedOut
);

  logic [31:0]         tickCount_reg;
  logic                msTick;
  logic [MS_WIDTH-1:0] gapMs_reg;
  logic                armed_reg;

  // ==========================================================
  // Millisecond tick
  assign msTick = (tickCount_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tickCount_reg <= 32'h0000_0000;
    end else if (msTick || pdoReceived) begin
      tickCount_reg <= 32'h0000_0000;
    end else begin
      tickCount_reg <= tickCount_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Gap counter, restarted by each process-data message
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gapMs_reg <= '0;
    end else if (pdoReceived) begin
      gapMs_reg <= '0;
    end else if (msTick && gapMs_reg != '1) begin
      gapMs_reg <= gapMs_reg + MS_WIDTH'(1);
    end
  end

  // ==========================================================
  // Armed by the first message, timeout of zero disables
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= 1'b0;
    end else if (pdoReceived) begin
      armed_reg <= 1'b1;
    end else if (keyCycle || nmtReceived) begin
      armed_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Latched fault, set on the tick that passes the timeout; set wins over a clear
  // Level compare would re-raise it right after a clear, so only the crossing sets
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timedOut <= 1'b0;
    end else if (armed_reg && msTick && !pdoReceived && timeoutMs != '0 && gapMs_reg == timeoutMs) begin
      timedOut <= 1'b1;
    end else if (keyCycle || nmtReceived) begin
      timedOut <= 1'b0;
    end
  end

endmodule

/* rtl/wiper_check_if.sv */
// Interface carrying one wiper sample, its fault limits and the verdict
`timescale 1ns/100ps
interface wiper_check_if #(
  parameter int WIDTH = 10
);
  logic [WIDTH-1:0] sample;
  logic [WIDTH-1:0] faultLow;
  logic [WIDTH-1:0] faultHigh;
  logic             inFault;

  modport checker_side (input sample, input faultLow, input faultHigh, output inFault);
  modport user_side    (output sample, output faultLow, output faultHigh, input inFault);
endinterface

/* rtl/wiper_range_check.sv */
// Range check of one wiper input against its fault limits
`timescale 1ns/100ps
module wiper_range_check (
  input  wire logic              mclk,
  input  wire logic              resetn,
  wiper_check_if.checker_side    chk
);

  // ==========================================================
  // Fault while at or beyond either limit, clears in range
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chk.inFault <= 1'b0;
    end else begin
      chk.inFault <= (chk.sample <= chk.faultLow) || (chk.sample >= chk.faultHigh);
    end
  end

endmodule
